/* pkg/motor_pwm_pkg.sv */
// constants, field layouts and carrier types of the motor pwm timer
// assumes a 40 MHz system clock and a 32-bit apb register port
package motor_pwm_pkg;
  // system clock rate
  localparam int CLK_HZ = 40_000_000;
  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_TIMER_CTL = 16'h1002;
  localparam logic [15:0] IDX_PWM_CTL1 = 16'h1003;
  localparam logic [15:0] IDX_OUT_EN = 16'h1004;
  localparam logic [15:0] IDX_POLARITY = 16'h1005;
  localparam logic [15:0] IDX_PER_LOW = 16'h1008;
  localparam logic [15:0] IDX_PER_HIGH = 16'h1009;
  localparam logic [15:0] IDX_DUTY_A_LOW = 16'h100A;
  localparam logic [15:0] IDX_DUTY_A_HIGH = 16'h100B;
  localparam logic [15:0] IDX_DUTY_B_LOW = 16'h100C;
  localparam logic [15:0] IDX_DUTY_B_HIGH = 16'h100D;
  localparam logic [15:0] IDX_DUTY_C_LOW = 16'h100E;
  localparam logic [15:0] IDX_DUTY_C_HIGH = 16'h100F;
  localparam logic [15:0] IDX_DELAY_A = 16'h1010;
  localparam logic [15:0] IDX_DELAY_B = 16'h1011;
  localparam logic [15:0] IDX_DELAY_C = 16'h1012;
  localparam logic [15:0] IDX_COMPARE = 16'h1013;
  localparam logic [15:0] IDX_CAPTURE = 16'h1014;
  localparam logic [15:0] IDX_COUNTER = 16'h1015;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PER_LOW = 8'hFF;
  localparam logic [7:0] RST_DUTY_LOW = 8'h7F;
  localparam logic [7:0] RST_COMPARE = 8'hFF;
  // widths
  localparam int PWM_W = 10;
  localparam int NUM_CH = 3;
  localparam int NUM_OUT = 6;
  // clock select code that is reserved in the 8-bit timer mode
  localparam logic [3:0] CLK_SEL_RESERVED = 4'hF;
  // dead time bound in timer clocks: 16 steps of 8; the largest delay reached is 15 steps of 8, 120
  localparam int DT_MAX_TICKS = 128;

  // timer control register layout
  typedef struct packed {
    logic wide_mode;
    logic op_mode_select;
    logic count_continue;
    logic count_start;
    logic [3:0] clk_sel;
  } tctl_s;

  // pwm control one layout
  typedef struct packed {
    logic pwm_mode_enable;
    logic external_sync_enable;
    logic up_down_count_enable;
    logic pwm_halt;
    logic immediate_update;
    logic tie_all_duties;
    logic [1:0] dead_time_prescale;
  } ctl1_s;

  // output enable control layout, enables ordered aa ab ba bb ca cb
  typedef struct packed {
    logic force_all_from_a;
    logic spare;
    logic [5:0] out_enable;
  } oen_s;

  // polarity control layout, polarities ordered aa ab ba bb ca cb
  typedef struct packed {
    logic hiz_clear;
    logic b_side_disable_level;
    logic [5:0] out_polarity;
  } pol_s;

  // direction of the pwm counter
  typedef enum logic {DIR_UP, DIR_DOWN} dir_e;
endpackage

/* logic/motor_pwm_timer.sv */
// eight-bit timer with a ten-bit three-channel six-output motor pwm mode
// assumes an apb master on clk, synchronous pin inputs, one clock domain
//
// Notes on behaviour
// RULE1 - mode bit clear: match toggles output
// RULE2 - mode bit set: capture count into register
// RULE3 - pwm registers act only in pwm mode; the code still lets the polarity bits set the idle pin levels outside it
// RULE4 - period is ten bits, low and high
// RULE5 - three ten-bit duties, low halves reset 7F
// RULE6 - sync disabled ignores blanking; enabled follows it
// RULE7 - no up/down: count up, wrap at period
// RULE8 - up/down: count up then down
// RULE9 - halt holds counter, disables outputs
// RULE10 - deferred update moves holding at period match
// RULE11 - immediate update takes values at once
// RULE12 - dead-time prescale divides by 1,2,4,8
// RULE13 - force-all drives every output from duty A
// RULE14 - one enable bit per output pin
// RULE15 - hi-z clear redrives pins, bit self-clears
// RULE16 - disabled b pin may copy a pin
// RULE17 - a polarity sets start and idle level
// RULE18 - b polarity selects copy or inverse
// RULE19 - four-bit delay per output, rising only
// RULE20 - software writes three timer clocks ahead
// RULE21 - low blanking resets counter and outputs
// RULE22 - up/down doubles effective period and duty
// RULE23 - longest edge delay is 128 timer clocks; the code reaches at most 120
// RULE24 - halves combine in holding before transfer
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module motor_pwm_timer
  import motor_pwm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic blanking_input,
  input wire logic capture_input,
  input wire logic hiz_request,
  output logic match_toggle_output,
  output logic [5:0] pwm_out,
  output logic [5:0] pwm_oe
);
  // reset release chain
  logic rst_meta;
  logic rst_n;

  // software registers
  logic [7:0] timer_control;
  logic [7:0] pwm_control_one;
  logic [7:0] pwm_output_enable_control;
  logic [7:0] pwm_polarity_control;
  logic [7:0] delay_reg [NUM_CH];
  logic [7:0] compare_data;
  logic [7:0] capture_data;
  // holding and active period / duty values
  logic [PWM_W-1:0] hold_per;
  logic [PWM_W-1:0] act_per;
  logic [PWM_W-1:0] hold_duty [NUM_CH];
  logic [PWM_W-1:0] act_duty [NUM_CH];
  // timer clock prescaler and 8-bit timer state
  logic [15:0] pre_cnt;
  logic [7:0] tmr_cnt;
  logic cap_prev;
  // pwm counter state
  logic [PWM_W-1:0] pwm_cnt;
  dir_e dir;
  // per-output delay state
  logic [6:0] dly_cnt [NUM_OUT];
  logic [NUM_OUT-1:0] wave_prev;

  // field views
  tctl_s tc;
  ctl1_s c1;
  oen_s oe;
  pol_s pc;
  assign tc = tctl_s'(timer_control);
  assign c1 = ctl1_s'(pwm_control_one);
  assign oe = oen_s'(pwm_output_enable_control);
  assign pc = pol_s'(pwm_polarity_control);

  // release reset through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // bus decode; unaligned accesses are refused and never write
  wire setup = psel & ~penable;
  wire aligned = (paddr[1:0] == 2'b00);
  wire wr_en = psel & penable & pready & pwrite & aligned;
  wire [15:0] idx = paddr[17:2];
  wire [7:0] wb = pwdata[7:0];
  wire hit_tctl = idx == IDX_TIMER_CTL;
  wire hit_ctl1 = idx == IDX_PWM_CTL1;
  wire hit_oen = idx == IDX_OUT_EN;
  wire hit_pol = idx == IDX_POLARITY;
  wire hit_perl = idx == IDX_PER_LOW;
  wire hit_perh = idx == IDX_PER_HIGH;
  wire hit_dal = idx == IDX_DUTY_A_LOW;
  wire hit_dah = idx == IDX_DUTY_A_HIGH;
  wire hit_dbl = idx == IDX_DUTY_B_LOW;
  wire hit_dbh = idx == IDX_DUTY_B_HIGH;
  wire hit_dcl = idx == IDX_DUTY_C_LOW;
  wire hit_dch = idx == IDX_DUTY_C_HIGH;
  wire hit_dlya = idx == IDX_DELAY_A;
  wire hit_dlyb = idx == IDX_DELAY_B;
  wire hit_dlyc = idx == IDX_DELAY_C;
  wire hit_cmp = idx == IDX_COMPARE;
  wire hit_cap = idx == IDX_CAPTURE;
  wire hit_cnt = idx == IDX_COUNTER;
  wire hit_any = hit_tctl | hit_ctl1 | hit_oen | hit_pol | hit_perl | hit_perh
               | hit_dal | hit_dah | hit_dbl | hit_dbh | hit_dcl | hit_dch
               | hit_dlya | hit_dlyb | hit_dlyc | hit_cmp | hit_cap | hit_cnt;
  // read-only registers refuse writes
  wire bad_acc = ~aligned | ~hit_any | (pwrite & (hit_cap | hit_cnt));
  // duty writes; writes to duty a also land in b and c when tied
  wire [NUM_CH-1:0] wr_dlow = {hit_dcl | (hit_dal & c1.tie_all_duties),
                               hit_dbl | (hit_dal & c1.tie_all_duties), hit_dal};
  wire [NUM_CH-1:0] wr_dhigh = {hit_dch | (hit_dah & c1.tie_all_duties),
                                hit_dbh | (hit_dah & c1.tie_all_duties), hit_dah};
  wire [NUM_CH-1:0] wr_dly = {hit_dlyc, hit_dlyb, hit_dlya};

  // counter view depends on mode
  wire [7:0] cnt_view = c1.pwm_mode_enable ? pwm_cnt[7:0] : tmr_cnt;
  // read data select; reserved bits read zero
  wire [7:0] rd_byte =
      hit_tctl ? timer_control :
      hit_ctl1 ? pwm_control_one :
      hit_oen ? pwm_output_enable_control :
      hit_pol ? pwm_polarity_control :
      hit_perl ? hold_per[7:0] :
      hit_perh ? {6'b0, hold_per[9:8]} :
      hit_dal ? hold_duty[0][7:0] :
      hit_dah ? {6'b0, hold_duty[0][9:8]} :
      hit_dbl ? hold_duty[1][7:0] :
      hit_dbh ? {6'b0, hold_duty[1][9:8]} :
      hit_dcl ? hold_duty[2][7:0] :
      hit_dch ? {6'b0, hold_duty[2][9:8]} :
      hit_dlya ? delay_reg[0] :
      hit_dlyb ? delay_reg[1] :
      hit_dlyc ? delay_reg[2] :
      hit_cmp ? compare_data :
      hit_cap ? capture_data :
      hit_cnt ? cnt_view : RST_ZERO;

  // apb answer: no wait state, data and status registered in setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
        pslverr <= bad_acc;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // control register writes; hi-z clear self-clears a cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control <= RST_ZERO;
      pwm_control_one <= RST_ZERO;
      pwm_output_enable_control <= RST_ZERO;
      pwm_polarity_control <= RST_ZERO;
      compare_data <= RST_COMPARE;
    end else begin
      if (wr_en && hit_tctl) timer_control <= wb;
      if (wr_en && hit_ctl1) pwm_control_one <= wb;
      if (wr_en && hit_oen) pwm_output_enable_control <= wb;
      if (wr_en && hit_cmp) compare_data <= wb;
      if (wr_en && hit_pol) begin
        pwm_polarity_control <= wb;
      end else begin
        pwm_polarity_control[7] <= 1'b0; // [RULE15]
      end
    end
  end

  // timer clock
  // prescaler divides clk by a power of two chosen by clk_sel
  wire [15:0] pre_lim = 16'((32'd1 << tc.clk_sel) - 32'd1);
  wire tick = (pre_cnt >= pre_lim) && (tc.clk_sel != CLK_SEL_RESERVED);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 16'h0000;
    end else begin
      pre_cnt <= tick ? 16'h0000 : pre_cnt + 16'h0001;
    end
  end

  // 8-bit timer / capture
  wire tmr_run = ~c1.pwm_mode_enable & tc.count_start & tc.count_continue;
  wire tmr_match = tmr_run & tick & (tmr_cnt == compare_data);
  wire cap_edge = capture_input & ~cap_prev;
  wire tmr_restart = wr_en & hit_tctl & wb[4];

  // counter clears on match and on a start write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_cnt <= RST_ZERO;
      match_toggle_output <= 1'b0;
      capture_data <= RST_ZERO;
      cap_prev <= 1'b0;
    end else begin
      cap_prev <= capture_input;
      if (tmr_restart) begin
        tmr_cnt <= RST_ZERO;
      end else if (tmr_match) begin
        tmr_cnt <= RST_ZERO;
      end else if (tmr_run && tick) begin
        tmr_cnt <= tmr_cnt + 8'h01;
      end
      // toggle only in the timer/counter mode
      if (tmr_match && !tc.op_mode_select) begin
        match_toggle_output <= ~match_toggle_output; // [RULE1]
      end
      // capture mode latches the running count
      if (tc.op_mode_select && cap_edge && !c1.pwm_mode_enable) begin
        capture_data <= tmr_cnt; // [RULE2]
      end
    end
  end

  // pwm counter
  // blanking acts only while external sync is on
  wire blanked = c1.external_sync_enable & ~blanking_input; // [RULE6]
  wire pwm_on = c1.pwm_mode_enable; // [RULE3]
  wire pwm_run = pwm_on & ~c1.pwm_halt & ~blanked;
  wire at_top = pwm_cnt >= act_per;
  // period match moves holding values in the deferred mode
  wire per_match = pwm_run & tick & at_top;
  wire load_act = c1.immediate_update | per_match; // [RULE10] [RULE11]

  // counter: reset by blanking or mode off, held by halt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt <= '0;
      dir <= DIR_UP;
    end else if (!pwm_on || blanked) begin
      pwm_cnt <= '0; // [RULE21]
      dir <= DIR_UP;
    end else if (c1.pwm_halt) begin
      pwm_cnt <= pwm_cnt; // [RULE9]
    end else if (tick) begin
      if (!c1.up_down_count_enable) begin
        dir <= DIR_UP;
        pwm_cnt <= at_top ? '0 : pwm_cnt + 10'd1; // [RULE7]
      end else begin
        // up then down gives twice the programmed period
        case (dir)
          DIR_UP: begin
            if (at_top) begin
              dir <= DIR_DOWN; // [RULE8] [RULE22]
              pwm_cnt <= (pwm_cnt == '0) ? '0 : pwm_cnt - 10'd1;
            end else begin
              pwm_cnt <= pwm_cnt + 10'd1;
            end
          end
          DIR_DOWN: begin
            if (pwm_cnt == '0) begin
              dir <= DIR_UP;
              pwm_cnt <= 10'd1;
            end else begin
              pwm_cnt <= pwm_cnt - 10'd1;
            end
          end
          default: begin
            dir <= DIR_UP;
          end
        endcase
      end
    end
  end

  // period holding and active copies
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_per <= {2'b00, RST_PER_LOW};
      act_per <= {2'b00, RST_PER_LOW};
    end else begin
      if (wr_en && hit_perl) hold_per[7:0] <= wb; // [RULE4]
      if (wr_en && hit_perh) hold_per[9:8] <= wb[1:0];
      // whole value moves at once, never half of it
      if (load_act) act_per <= hold_per; // [RULE24]
    end
  end

  // per channel duty holding, active copy and delay register
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hold_duty[ch] <= {2'b00, RST_DUTY_LOW}; // [RULE5]
          act_duty[ch] <= {2'b00, RST_DUTY_LOW};
          delay_reg[ch] <= RST_ZERO;
        end else begin
          if (wr_en && wr_dlow[ch]) hold_duty[ch][7:0] <= wb;
          if (wr_en && wr_dhigh[ch]) hold_duty[ch][9:8] <= wb[1:0];
          if (wr_en && wr_dly[ch]) delay_reg[ch] <= wb;
          if (load_act) act_duty[ch] <= hold_duty[ch]; // [RULE24]
        end
      end
    end
  endgenerate

  // output stage
  // raw channel waves; force-all takes every channel from duty a
  logic [NUM_CH-1:0] raw;
  logic [NUM_OUT-1:0] wave;
  logic [NUM_OUT-1:0] next_pin;
  logic [NUM_OUT-1:0] idle_lvl;
  logic [NUM_OUT-1:0] en;
  logic [NUM_OUT-1:0] pol;
  logic [3:0] dly [NUM_OUT];

  genvar o;
  generate
    for (o = 0; o < NUM_OUT; o++) begin : g_out
      // bit order of the control registers runs aa first from bit 5
      assign en[o] = oe.out_enable[NUM_OUT-1-o]; // [RULE14]
      assign pol[o] = pc.out_polarity[NUM_OUT-1-o];
      // a side in upper nibble, b side in lower
      assign dly[o] = (o % 2 == 0) ? delay_reg[o/2][7:4] : delay_reg[o/2][3:0];
      if (o % 2 == 0) begin : g_a
        assign raw[o/2] = pwm_cnt < (oe.force_all_from_a ? act_duty[0]
                                                          : act_duty[o/2]); // [RULE13]
        // a side starts high unless inverted; idles at its polarity
        assign wave[o] = pol[o] ? ~raw[o/2] : raw[o/2]; // [RULE17]
        assign idle_lvl[o] = pol[o];
      end else begin : g_b
        // b side copies or inverts the a side wave
        assign wave[o] = pol[o] ? ~wave[o-1] : wave[o-1]; // [RULE18]
        assign idle_lvl[o] = pc.b_side_disable_level ? next_pin[o-1]
                                                      : pol[o]; // [RULE16]
      end

      // rising edge of the wave loads the delay, falling passes at once
      wire rise = wave[o] & ~wave_prev[o];
      // delay length in timer ticks: nibble scaled by 1, 2, 4 or 8
      wire [6:0] dly_len = {3'b000, dly[o]} << c1.dead_time_prescale; // [RULE12] [RULE23]
      wire held = (dly_cnt[o] != 7'h00) | (rise & (dly[o] != 4'h0));
      wire live = pwm_run & en[o];
      assign next_pin[o] = live ? (wave[o] & ~held) : idle_lvl[o]; // [RULE19]

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          wave_prev[o] <= 1'b0;
          dly_cnt[o] <= 7'h00;
          pwm_out[o] <= 1'b0;
        end else begin
          wave_prev[o] <= live & wave[o];
          if (!live) begin
            dly_cnt[o] <= 7'h00;
          end else if (rise) begin
            // the rise cycle itself is the first held cycle
            dly_cnt[o] <= (dly_len == 7'h00) ? 7'h00 : dly_len - 7'h01;
          end else if (tick && dly_cnt[o] != 7'h00) begin
            dly_cnt[o] <= dly_cnt[o] - 7'h01;
          end
          pwm_out[o] <= next_pin[o];
        end
      end
    end
  endgenerate

  // pin drive: a fault request floats the pins, the clear bit redrives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_oe <= 6'h3F;
    end else if (hiz_request) begin
      pwm_oe <= 6'h00;
    end else if (pc.hiz_clear) begin
      pwm_oe <= 6'h3F; // [RULE15]
    end
  end

endmodule // motor_pwm_timer

/* test/motor_pwm_timer_assertions.sv */
// checker of the motor pwm timer ports
// assumes a bind into motor_pwm_timer
`timescale 1ns/1ps
module motor_pwm_timer_checker
  import motor_pwm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic blanking_input,
  input wire logic hiz_request,
  input wire logic [5:0] pwm_out,
  input wire logic [5:0] pwm_oe
);
  logic wr_ok; // a write lands at this edge
  logic [15:0] idx; // register index
  logic settled; // config quiet, no delays
  logic run; // pwm running unblanked
  ctl1_s c1; // pwm ctl copy
  oen_s oe_r; // enables copy
  pol_s pl; // polarity copy
  logic [23:0] dly; // delays copy
  logic [7:0] quiet; // cycles since a write
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign idx = paddr[17:2];
  assign settled = (quiet > 8'h3C) && (dly == 24'h0);
  assign run = c1.pwm_mode_enable && !c1.pwm_halt && (blanking_input || !c1.external_sync_enable);
  // shadow writes to predict pin levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c1 <= '0;
      oe_r <= '0;
      pl <= '0;
      dly <= '0;
      quiet <= '0;
    end else if (wr_ok) begin
      quiet <= 8'h00;
      if (idx == IDX_PWM_CTL1) c1 <= ctl1_s'(pwdata[7:0]);
      if (idx == IDX_OUT_EN) oe_r <= oen_s'(pwdata[7:0]);
      if (idx == IDX_POLARITY) pl <= pol_s'(pwdata[7:0]);
      if (idx == IDX_DELAY_A) dly[23:16] <= pwdata[7:0];
      if (idx == IDX_DELAY_B) dly[15:8] <= pwdata[7:0];
      if (idx == IDX_DELAY_C) dly[7:0] <= pwdata[7:0];
    end else if (quiet != 8'hFF) begin
      quiet <= quiet + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence setup_s; psel && !penable; endsequence
  sequence clear_hiz_s; wr_ok && idx == IDX_POLARITY && pwdata[7]; endsequence
  sequence blanked_s;
    (quiet > 8'h08 && dly == 24'h0 && c1.external_sync_enable && !blanking_input) [*3];
  endsequence
  apb_answer_a: assert property (setup_s |=> pready ##1 !pready)
    else $error("apb answer not in the access cycle");
  hiz_float_a: assert property (hiz_request [*3] |-> pwm_oe == 6'h00)
    else $error("pins still driven under hi-z request");
  hiz_restore_a: assert property (clear_hiz_s ##1 !hiz_request [*3] |-> pwm_oe == 6'h3F)
    else $error("pins not driven after hi-z clear");
  halt_idle_a: assert property (settled && c1.pwm_halt |-> pwm_out[0] == pl.out_polarity[5])
    else $error("halted a pin not at idle level");
  idle_level_a: assert property (settled && !(c1.pwm_mode_enable && oe_r.out_enable[5])
    |-> pwm_out[0] == pl.out_polarity[5])
    else $error("disabled a pin not at idle level");
  b_follow_a: assert property (settled && run && oe_r.out_enable[5:4] == 2'b11 && !pl.out_polarity[5]
    |-> pwm_out[1] == (pwm_out[0] ^ pl.out_polarity[4]))
    else $error("b pin not tied to a pin");
  b_copy_a: assert property (settled && pl.b_side_disable_level && oe_r.out_enable[5:4] == 2'b00
    |-> pwm_out[1] == pwm_out[0])
    else $error("disabled b pin not at a pin level");
  force_all_a: assert property (settled && run && oe_r == 8'hBF && pl.out_polarity == 6'h00
    |-> pwm_out[2] == pwm_out[0] && pwm_out[4] == pwm_out[0])
    else $error("forced pins differ from a pin");
  blank_reset_a: assert property (blanked_s |-> pwm_out[0] == pl.out_polarity[5])
    else $error("blanked a pin not at reset level");
endmodule // motor_pwm_timer_checker

bind motor_pwm_timer motor_pwm_timer_checker motor_pwm_timer_checker_inst (.clk(clk),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .blanking_input(blanking_input),
  .hiz_request(hiz_request), .pwm_out(pwm_out), .pwm_oe(pwm_oe));

/* test/power_stage.sv */
// power stage model: six gates fed by the pwm pins
// assumes undriven pins float; sampled on clk
`timescale 1ns/1ps
module power_stage (
  input wire logic clk,
  input wire logic [5:0] pwm_out,
  input wire logic [5:0] pwm_oe,
  input wire logic meter_clear,
  output logic [5:0] phase_level,
  output int high_count,
  output int rise_count
);
  logic [5:0] last = 6'h00; // last driven level per gate
  logic prev = 1'b0; // aa gate level one edge ago
  // floating gate, no pull: inverse of last level
  assign phase_level = (pwm_out & pwm_oe) | (~last & ~pwm_oe);
  // track driven levels, meter the aa gate
  always @(posedge clk) begin
    last <= (pwm_out & pwm_oe) | (last & ~pwm_oe);
    prev <= phase_level[0];
    if (meter_clear) begin
      high_count <= 0;
      rise_count <= 0;
    end else begin
      high_count <= high_count + int'(phase_level[0]);
      rise_count <= rise_count + int'(phase_level[0] && !prev);
    end
  end
endmodule // power_stage

/* test/test_ten_bit_motor_pwm_timer.sv */
// self-checking bench for the motor pwm timer and power stage
// assumes package, design, checker and model compile first
`timescale 1ns/1ps
module test_ten_bit_motor_pwm_timer;
  import motor_pwm_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic blanking_input = 1'b1;
  logic capture_input = 1'b0, hiz_request = 1'b0, meter_clear = 1'b0;
  logic [31:0] prdata, rdat, keep;
  logic pready, pslverr, rerr, match_toggle_output;
  logic [5:0] pwm_out, pwm_oe, phase_level;
  int high_count, rise_count;
  int fails = 0, checks_done = 0;
  always #12.5 clk = ~clk;
  motor_pwm_timer motor_pwm_timer_inst (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .blanking_input(blanking_input),
    .capture_input(capture_input), .hiz_request(hiz_request),
    .match_toggle_output(match_toggle_output), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
  power_stage power_stage_inst (.clk(clk), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .meter_clear(meter_clear), .phase_level(phase_level), .high_count(high_count),
    .rise_count(rise_count));
  // verdict and end of run
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // one apb transfer; holds the request until pready is seen
  task xf(input logic w, input logic [15:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // meter aa gate over n cycles; negative figure skips
  task meas(input int n, input int eh, input int er);
    @(posedge clk);
    meter_clear <= 1'b1;
    @(posedge clk);
    meter_clear <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
    if (eh >= 0) chk("high time", high_count, eh);
    if (er >= 0) chk("rising edges", rise_count, er);
  endtask
  task pwm_set(input logic [9:0] per, input logic [9:0] dut, input logic [7:0] ctl, input int wt);
    xf(1, IDX_PWM_CTL1, ctl);
    xf(1, IDX_PER_LOW, per[7:0]);
    xf(1, IDX_PER_HIGH, {6'h0, per[9:8]});
    xf(1, IDX_DUTY_A_LOW, dut[7:0]);
    xf(1, IDX_DUTY_A_HIGH, {6'h0, dut[9:8]});
    repeat (wt) @(posedge clk);
  endtask
  task t_regs;
    logic [15:0] ix [8] = '{IDX_TIMER_CTL, IDX_PWM_CTL1, IDX_PER_LOW, IDX_PER_HIGH,
      IDX_DUTY_A_LOW, IDX_DUTY_B_LOW, IDX_DUTY_C_LOW, IDX_DELAY_C};
    logic [7:0] ex [8] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h7F, 8'h7F, 8'h7F, 8'h00};
    for (int k = 0; k < 8; k++) begin
      xf(0, ix[k], 8'h00);
      chk("reset value", rdat, {24'h0, ex[k]});
    end
    xf(0, 16'h1006, 8'h00);
    chk("unmapped error", 32'(rerr), 32'h1);
    xf(1, IDX_CAPTURE, 8'h55);
    chk("read-only error", 32'(rerr), 32'h1);
    xf(1, IDX_PWM_CTL1, 8'h04);
    xf(1, IDX_DUTY_A_LOW, 8'h5A);
    xf(0, IDX_DUTY_C_LOW, 8'h00);
    chk("tied duty", rdat, 32'h5A);
  endtask
  task t_update;
    xf(1, IDX_OUT_EN, 8'h3F);
    pwm_set(10'h003, 10'h001, 8'h88, 60);
    meas(400, 100, 100);
    pwm_set(10'h103, 10'h101, 8'h88, 600);
    meas(520, 514, 2);
    pwm_set(10'h003, 10'h001, 8'h80, 0);
    meas(30, -1, -1);
    chk("early transfer", 32'(rise_count < 2), 32'h1);
    repeat (300) @(posedge clk);
    meas(400, 100, 100);
  endtask
  task t_updown;
    pwm_set(10'h008, 10'h003, 8'hA8, 60);
    meas(160, -1, 10);
    pwm_set(10'h003, 10'h001, 8'h88, 60);
  endtask
  task t_halt;
    xf(1, IDX_PWM_CTL1, 8'h98);
    repeat (80) @(posedge clk);
    meas(100, 0, 0);
    xf(0, IDX_COUNTER, 8'h00);
    keep = rdat;
    repeat (10) @(posedge clk);
    xf(0, IDX_COUNTER, 8'h00);
    chk("held count", rdat, keep);
    xf(1, IDX_PWM_CTL1, 8'h88);
    meas(400, 100, 100);
  endtask
  task t_blank;
    blanking_input <= 1'b0;
    meas(400, 100, 100);
    xf(1, IDX_PWM_CTL1, 8'hC8);
    meas(400, 0, 0);
    blanking_input <= 1'b1;
    meas(400, 100, 100);
  endtask
  task t_delay;
    pwm_set(10'h1FF, 10'h100, 8'h88, 600);
    for (int c = 0; c < 4; c++) begin
      xf(1, IDX_PWM_CTL1, 8'h88 | 8'(c));
      xf(1, IDX_DELAY_A, 8'hF0);
      repeat (600) @(posedge clk);
      meas(1024, 2 * (256 - (15 << c)), 2);
    end
    xf(1, IDX_DELAY_A, 8'h00);
    pwm_set(10'h003, 10'h001, 8'h88, 60);
  endtask
  task t_pol;
    xf(1, IDX_POLARITY, 8'h60);
    xf(1, IDX_OUT_EN, 8'h00);
    repeat (80) @(posedge clk);
    chk("idle levels", 32'(phase_level[1:0]), 32'h3);
    xf(1, IDX_POLARITY, 8'h00);
    xf(1, IDX_OUT_EN, 8'h1F);
    repeat (80) @(posedge clk);
    meas(100, 0, 0);
    xf(1, IDX_POLARITY, 8'h10);
    xf(1, IDX_OUT_EN, 8'h3F);
    repeat (80) @(posedge clk);
    xf(1, IDX_POLARITY, 8'h00);
    xf(1, IDX_DUTY_B_LOW, 8'h02);
    xf(1, IDX_OUT_EN, 8'hBF);
    repeat (80) @(posedge clk);
    meas(400, 100, 100);
    xf(1, IDX_OUT_EN, 8'h3F);
  endtask
  task t_hiz;
    hiz_request <= 1'b1;
    repeat (4) @(posedge clk);
    chk("floated pins", 32'(pwm_oe), 32'h0);
    hiz_request <= 1'b0;
    xf(1, IDX_POLARITY, 8'h80);
    repeat (4) @(posedge clk);
    chk("driven pins", 32'(pwm_oe), 32'h3F);
    xf(0, IDX_POLARITY, 8'h00);
    chk("clear bit", 32'(rdat[7]), 32'h0);
  endtask
  task t_timer;
    logic prev;
    int tg;
    xf(1, IDX_PWM_CTL1, 8'h00);
    xf(1, IDX_COMPARE, 8'h04);
    xf(1, IDX_TIMER_CTL, 8'h30);
    prev = match_toggle_output;
    tg = 0;
    repeat (200) begin
      @(posedge clk);
      if (match_toggle_output !== prev) tg++;
      prev = match_toggle_output;
    end
    chk("match toggles", 32'(tg > 30 && tg < 50), 32'h1);
    meas(100, 0, 0);
    xf(1, IDX_TIMER_CTL, 8'h70);
    capture_input <= 1'b1;
    repeat (3) @(posedge clk);
    capture_input <= 1'b0;
    xf(0, IDX_CAPTURE, 8'h00);
    keep = rdat;
    repeat (7) @(posedge clk);
    xf(0, IDX_CAPTURE, 8'h00);
    chk("latched capture", rdat, keep);
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    summarize();
  end
  // reset, then every scenario in turn
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_update();
    t_updown();
    t_halt();
    t_blank();
    t_delay();
    t_pol();
    t_hiz();
    t_timer();
    summarize();
  end
endmodule // test_ten_bit_motor_pwm_timer
